// [design/pwsl_map.svh]
`ifndef PWSL_MAP_SVH
`define PWSL_MAP_SVH

// register byte offsets
`define PWSL_LOADING_CONTROL_WORD 8'h00
`define PWSL_COUNTER_CONTROL_WORD 8'h04
`define PWSL_COUNTER_RUN_WORD 8'h08
`define PWSL_LOAD_WINDOW_WORD 8'h0c
`define PWSL_SEL 8'h10
`define PWSL_PERIOD 8'h14
`define PWSL_COMPARE 8'h18
`define PWSL_FT_COMPARE 8'h1c
`define PWSL_ACTION_A 8'h20
`define PWSL_ACTION_B 8'h24
`define PWSL_STATUS 8'h28
`define PWSL_PERIOD_WORKING_BUFFER_RD 8'h2c
`define PWSL_CBUF_RD 8'h30
`define PWSL_CNT_RD 8'h34

// field positions
`define PWSL_CTRLD_LSB 0
`define PWSL_WINLD_LSB 8
`define PWSL_IMMLD_LSB 16
`define PWSL_CNTMODE_LSB 16
`define PWSL_CNTTYPE_LSB 0
`define PWSL_OUTMODE_LSB 24

// reset values
`define PWSL_RST_WORD 32'h0000_0000
`define PWSL_RST_VAL16 16'h0000

// timing counts
`define PWSL_CNT_MAX 16'hffff
`define PWSL_ACK_CYCLES 1

`endif

// [design/pwsl_pkg.sv]
package pwsl_pkg;
    typedef enum logic [1:0] {
        PWSL_UP,
        PWSL_DOWN,
        PWSL_UPDOWN,
        PWSL_RSVD
    } pwsl_cnt_type_t;

    typedef enum logic [1:0] {
        PWSL_ACT_NONE,
        PWSL_ACT_LOW,
        PWSL_ACT_HIGH,
        PWSL_ACT_TOGGLE
    } pwsl_action_t;

    typedef enum logic [1:0] {
        PWSL_BUS_IDLE,
        PWSL_BUS_ACK
    } pwsl_bus_state_t;
endpackage

// [design/pwsl_channel.sv]
`include "pwsl_map.svh"

module pwsl_channel (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // control
    input wire logic i_tick,
    input wire logic i_run,
    input wire logic i_one_shot,
    input wire logic i_imm,
    input wire logic i_win,
    input wire logic i_ctr,
    input wire logic i_open_window,
    input wire pwsl_pkg::pwsl_cnt_type_t i_type,
    // software writes
    input wire logic i_wr_period,
    input wire logic i_wr_compare,
    input wire logic i_wr_ft,
    input wire logic [15:0] i_wdata,
    // state out
    output logic [15:0] o_counter_value,
    output logic o_dir_up,
    output logic [15:0] o_period_buf,
    output logic [15:0] o_compare_buf,
    output logic [15:0] o_ft_buf,
    output logic o_window_open,
    output logic o_running
);
    logic [15:0] period_value;
    logic [15:0] compare_value;
    logic [15:0] ft_value;
    logic shot_pending;
    logic period_end;
    logic center_pt;

    always_comb begin
        period_end = 1'b0;
        center_pt = 1'b0;
        if (i_tick && o_running) begin
            case (i_type)
                pwsl_pkg::PWSL_UP: period_end = (o_counter_value == o_period_buf);
                pwsl_pkg::PWSL_DOWN: period_end = (o_counter_value == 16'h0000);
                pwsl_pkg::PWSL_UPDOWN: begin
                    period_end = !o_dir_up && (o_counter_value == 16'h0001 || o_period_buf == 16'h0000);
                    center_pt = o_dir_up && (o_counter_value == o_period_buf);
                end
                default: period_end = 1'b0;
            endcase
        end
    end

    // software-side values
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            period_value <= `PWSL_RST_VAL16;
            compare_value <= `PWSL_RST_VAL16;
            ft_value <= `PWSL_RST_VAL16;
        end else begin
            if (i_wr_period) period_value <= i_wdata;
            if (i_wr_compare) compare_value <= i_wdata;
            if (i_wr_ft) ft_value <= i_wdata;
        end
    end

    // working buffers
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_period_buf <= `PWSL_RST_VAL16;
            o_compare_buf <= `PWSL_RST_VAL16;
            o_ft_buf <= `PWSL_RST_VAL16;
        end else if (i_imm) begin
            if (i_wr_period) o_period_buf <= i_wdata;
            if (i_wr_compare) o_compare_buf <= i_wdata;
            if (i_wr_ft) o_ft_buf <= i_wdata;
        end else begin
            if (period_end) o_period_buf <= period_value;
            if ((period_end && !(i_ctr && i_type == pwsl_pkg::PWSL_UPDOWN) && (!i_win || o_window_open)) ||
                (center_pt && i_ctr && (!i_win || o_window_open))) begin
                o_compare_buf <= compare_value;
                o_ft_buf <= ft_value;
            end
        end
    end

    // load window
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_window_open <= 1'b0;
        end else if (i_open_window) begin
            o_window_open <= 1'b1;
        end else if (period_end) begin
            o_window_open <= 1'b0;
        end
    end

    // one-shot trigger
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || !i_one_shot) begin
            shot_pending <= 1'b0;
        end else if (i_wr_compare && !period_end && !(i_run && !o_running)) begin
            // only a write that cannot start a shot at once queues one more
            shot_pending <= 1'b1;
        end else if (period_end || (i_run && !o_running)) begin
            shot_pending <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || !i_run) begin
            o_running <= 1'b0;
        end else if (!i_one_shot) begin
            o_running <= 1'b1;
        end else if (!o_running) begin
            o_running <= shot_pending || i_wr_compare;
        end else if (period_end) begin
            o_running <= shot_pending || i_wr_compare;
        end
    end

    // counter
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || !i_run) begin
            o_counter_value <= `PWSL_RST_VAL16;
            o_dir_up <= 1'b1;
        end else if (!o_running || o_period_buf == 16'h0000) begin
            o_counter_value <= `PWSL_RST_VAL16;
            o_dir_up <= 1'b1;
        end else if (i_tick) begin
            case (i_type)
                pwsl_pkg::PWSL_UP: begin
                    // above the period the count runs on to the top and wraps
                    o_counter_value <= period_end ? 16'h0000 : o_counter_value + 16'h0001;
                end
                pwsl_pkg::PWSL_DOWN: begin
                    o_counter_value <= period_end ? (i_imm ? o_period_buf : period_value) : o_counter_value - 16'h0001;
                end
                pwsl_pkg::PWSL_UPDOWN: begin
                    if (o_dir_up && o_counter_value >= o_period_buf) begin
                        o_dir_up <= 1'b0;
                        o_counter_value <= o_counter_value - 16'h0001;
                    end else if (!o_dir_up && o_counter_value == 16'h0000) begin
                        o_dir_up <= 1'b1;
                        o_counter_value <= 16'h0001;
                    end else if (o_dir_up) begin
                        o_counter_value <= o_counter_value + 16'h0001;
                    end else begin
                        o_counter_value <= o_counter_value - 16'h0001;
                    end
                end
                default: o_counter_value <= o_counter_value;
            endcase
        end
    end
endmodule

// [design/pwsl_top.sv]
`include "pwsl_map.svh"

module pwsl_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // prescaled counter clock enable
    input wire logic [5:0] i_tick,
    // avalon-mm slave
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // to downstream stages
    output logic [5:0] o_waveform,
    output logic [15:0] o_counter_value [6],
    output logic [5:0] o_dir_up
);
    logic [31:0] loading_control_word;
    logic [31:0] counter_control_word;
    logic [5:0] counter_run_word;
    logic [2:0] sel;
    logic [11:0] waveform_action_ctrl_a [6];
    logic [11:0] waveform_action_ctrl_b [6];
    logic [5:0] window_open;
    logic [5:0] running;
    logic [15:0] period_buf [6];
    logic [15:0] compare_buf [6];
    logic [15:0] ft_buf [3];
    logic [1:0] cnt_type [6];
    logic [2:0] out_mode;
    logic ack;
    logic [31:0] wmask;
    logic [31:0] next_readdata;
    logic wr_cyc;
    logic rd_cyc;

    assign wmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}}, {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
    assign wr_cyc = i_write && !ack;
    assign rd_cyc = i_read && !ack;
    assign o_waitrequest = (i_read || i_write) && !ack;
    assign out_mode = counter_control_word[`PWSL_OUTMODE_LSB +: 3];

    // bus handshake: one wait cycle per access
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ack <= 1'b0;
        end else begin
            ack <= (i_read || i_write) && !ack;
        end
    end

    // control registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            loading_control_word <= `PWSL_RST_WORD;
            counter_control_word <= `PWSL_RST_WORD;
            counter_run_word <= 6'h00;
            sel <= 3'h0;
        end else if (wr_cyc) begin
            case (i_address)
                `PWSL_LOADING_CONTROL_WORD:
                    loading_control_word <= (loading_control_word & ~wmask) | (i_writedata & wmask & 32'h003f_3f3f);
                `PWSL_COUNTER_CONTROL_WORD:
                    counter_control_word <= (counter_control_word & ~wmask) | (i_writedata & wmask & 32'h073f_0fff);
                `PWSL_COUNTER_RUN_WORD: if (i_byteenable[0]) counter_run_word <= i_writedata[5:0];
                `PWSL_SEL: if (i_byteenable[0]) sel <= (i_writedata[2:0] > 3'h5) ? 3'h5 : i_writedata[2:0];
                default: sel <= sel;
            endcase
        end
    end

    // read mux
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (i_address)
            `PWSL_LOADING_CONTROL_WORD: next_readdata = loading_control_word;
            `PWSL_COUNTER_CONTROL_WORD: next_readdata = counter_control_word;
            `PWSL_COUNTER_RUN_WORD: next_readdata = {26'h0, counter_run_word};
            `PWSL_LOAD_WINDOW_WORD: next_readdata = {26'h0, window_open};
            `PWSL_SEL: next_readdata = {29'h0, sel};
            `PWSL_ACTION_A: next_readdata = {20'h0, waveform_action_ctrl_a[sel]};
            `PWSL_ACTION_B: next_readdata = {20'h0, waveform_action_ctrl_b[sel]};
            `PWSL_STATUS: next_readdata = {10'h0, o_dir_up, 10'h0, running};
            `PWSL_PERIOD_WORKING_BUFFER_RD: next_readdata = {16'h0, period_buf[sel]};
            `PWSL_CBUF_RD: next_readdata = {16'h0, compare_buf[sel]};
            `PWSL_FT_COMPARE: next_readdata = {16'h0, ft_buf[sel[2:1]]};
            `PWSL_CNT_RD: next_readdata = {15'h0, o_dir_up[sel], o_counter_value[sel]};
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_readdata <= `PWSL_RST_WORD;
        end else if (rd_cyc) begin
            o_readdata <= next_readdata;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_ch
            logic is_sel;
            logic [15:0] cmp_cnt;
            logic cmp_up;
            logic [15:0] ft_unused;
            logic ev_zero;
            logic ev_period;
            logic ev_own_u;
            logic ev_own_d;
            logic ev_mate_u;
            logic ev_mate_d;
            logic [1:0] act;
            logic ph_up;
            pwsl_pkg::pwsl_cnt_type_t ctype;

            assign is_sel = (sel == 3'(g));
            assign cnt_type[g] = counter_control_word[2 * g +: 2];
            assign ctype = pwsl_pkg::pwsl_cnt_type_t'(cnt_type[g]);

            always_ff @(posedge i_clk) begin
                if (!i_rst_b) begin
                    waveform_action_ctrl_a[g] <= 12'h000;
                    waveform_action_ctrl_b[g] <= 12'h000;
                end else if (wr_cyc && is_sel && i_address == `PWSL_ACTION_A) begin
                    waveform_action_ctrl_a[g] <= i_writedata[11:0];
                end else if (wr_cyc && is_sel && i_address == `PWSL_ACTION_B) begin
                    waveform_action_ctrl_b[g] <= i_writedata[11:0];
                end
            end

            pwsl_channel u_ch (
                .i_clk(i_clk),
                .i_rst_b(i_rst_b),
                .i_tick(i_tick[g]),
                .i_run(counter_run_word[g]),
                .i_one_shot(counter_control_word[`PWSL_CNTMODE_LSB + g]),
                .i_imm(loading_control_word[`PWSL_IMMLD_LSB + g]),
                .i_win(loading_control_word[`PWSL_WINLD_LSB + g]),
                .i_ctr(loading_control_word[`PWSL_CTRLD_LSB + g]),
                .i_open_window(wr_cyc && i_address == `PWSL_LOAD_WINDOW_WORD && i_writedata[g]),
                .i_type(ctype),
                .i_wr_period(wr_cyc && is_sel && i_address == `PWSL_PERIOD),
                .i_wr_compare(wr_cyc && is_sel && i_address == `PWSL_COMPARE),
                .i_wr_ft(wr_cyc && is_sel && i_address == `PWSL_FT_COMPARE && g % 2 == 0),
                .i_wdata(i_writedata[15:0]),
                .o_counter_value(o_counter_value[g]),
                .o_dir_up(o_dir_up[g]),
                .o_period_buf(period_buf[g]),
                .o_compare_buf(compare_buf[g]),
                .o_ft_buf(ft_unused),
                .o_window_open(window_open[g]),
                .o_running(running[g])
            );
            if (g % 2 == 0) begin : g_ft
                assign ft_buf[g / 2] = ft_unused;
            end

            // complementary pair: odd channel follows even counter
            assign cmp_cnt = (out_mode[g / 2] && g % 2 == 1) ? o_counter_value[g - 1] : o_counter_value[g];
            assign cmp_up = (out_mode[g / 2] && g % 2 == 1) ? o_dir_up[g - 1] : o_dir_up[g];

            always_comb begin
                ev_zero = i_tick[g] && running[g] && (cmp_cnt == 16'h0000);
                ev_period = i_tick[g] && running[g] && (cmp_cnt == period_buf[g]);
                ev_own_u = i_tick[g] && running[g] && cmp_up && (cmp_cnt == compare_buf[g]);
                ev_own_d = i_tick[g] && running[g] && !cmp_up && (cmp_cnt == compare_buf[g]);
                ev_mate_u = 1'b0;
                ev_mate_d = 1'b0;
                if (out_mode[g / 2]) begin
                    ev_mate_u = i_tick[g] && running[g] && cmp_up && (cmp_cnt == compare_buf[g ^ 1]);
                    ev_mate_d = i_tick[g] && running[g] && !cmp_up && (cmp_cnt == compare_buf[g ^ 1]);
                end
                // ctrl a: zero[1:0] period[3:2] own up[5:4] own down[7:6]
                // ctrl b: mate up[5:4] mate down[7:6]
                // zero tick ranks with the up phase, period tick with the down phase
                ph_up = (cmp_cnt == 16'h0000) || (cmp_up && cmp_cnt != period_buf[g]);
                act = 2'h0;
                case (ctype)
                    pwsl_pkg::PWSL_UP: begin
                        if (ev_period) act = waveform_action_ctrl_a[g][3:2];
                        else if (g % 2 == 1 ? ev_own_u : ev_mate_u) act = g % 2 == 1 ?
                            waveform_action_ctrl_a[g][5:4] : waveform_action_ctrl_b[g][5:4];
                        else if (g % 2 == 1 ? ev_mate_u : ev_own_u) act = g % 2 == 1 ?
                            waveform_action_ctrl_b[g][5:4] : waveform_action_ctrl_a[g][5:4];
                        else if (ev_zero) act = waveform_action_ctrl_a[g][1:0];
                    end
                    pwsl_pkg::PWSL_DOWN: begin
                        if (ev_zero) act = waveform_action_ctrl_a[g][1:0];
                        else if (g % 2 == 1 ? ev_own_d : ev_mate_d) act = g % 2 == 1 ?
                            waveform_action_ctrl_a[g][7:6] : waveform_action_ctrl_b[g][7:6];
                        else if (g % 2 == 1 ? ev_mate_d : ev_own_d) act = g % 2 == 1 ?
                            waveform_action_ctrl_b[g][7:6] : waveform_action_ctrl_a[g][7:6];
                        else if (ev_period) act = waveform_action_ctrl_a[g][3:2];
                    end
                    pwsl_pkg::PWSL_UPDOWN: begin
                        if (ph_up) begin
                            if (g % 2 == 1 ? ev_own_u : ev_mate_u) act = g % 2 == 1 ?
                                waveform_action_ctrl_a[g][5:4] : waveform_action_ctrl_b[g][5:4];
                            else if (g % 2 == 1 ? ev_mate_u : ev_own_u) act = g % 2 == 1 ?
                                waveform_action_ctrl_b[g][5:4] : waveform_action_ctrl_a[g][5:4];
                            else if (ev_zero) act = waveform_action_ctrl_a[g][1:0];
                            else if (g % 2 == 1 ? ev_own_d : ev_mate_d) act = g % 2 == 1 ?
                                waveform_action_ctrl_a[g][7:6] : waveform_action_ctrl_b[g][7:6];
                            else if (g % 2 == 1 ? ev_mate_d : ev_own_d) act = g % 2 == 1 ?
                                waveform_action_ctrl_b[g][7:6] : waveform_action_ctrl_a[g][7:6];
                        end else begin
                            if (g % 2 == 1 ? ev_own_d : ev_mate_d) act = g % 2 == 1 ?
                                waveform_action_ctrl_a[g][7:6] : waveform_action_ctrl_b[g][7:6];
                            else if (g % 2 == 1 ? ev_mate_d : ev_own_d) act = g % 2 == 1 ?
                                waveform_action_ctrl_b[g][7:6] : waveform_action_ctrl_a[g][7:6];
                            else if (ev_period) act = waveform_action_ctrl_a[g][3:2];
                            else if (g % 2 == 1 ? ev_own_u : ev_mate_u) act = g % 2 == 1 ?
                                waveform_action_ctrl_a[g][5:4] : waveform_action_ctrl_b[g][5:4];
                            else if (g % 2 == 1 ? ev_mate_u : ev_own_u) act = g % 2 == 1 ?
                                waveform_action_ctrl_b[g][5:4] : waveform_action_ctrl_a[g][5:4];
                        end
                    end
                    default: act = 2'h0;
                endcase
            end

            always_ff @(posedge i_clk) begin
                if (!i_rst_b) begin
                    o_waveform[g] <= 1'b0;
                end else begin
                    case (pwsl_pkg::pwsl_action_t'(act))
                        pwsl_pkg::PWSL_ACT_LOW: o_waveform[g] <= 1'b0;
                        pwsl_pkg::PWSL_ACT_HIGH: o_waveform[g] <= 1'b1;
                        pwsl_pkg::PWSL_ACT_TOGGLE: o_waveform[g] <= !o_waveform[g];
                        default: o_waveform[g] <= o_waveform[g];
                    endcase
                end
            end
        end
    endgenerate
endmodule

// [testbench/pwsl_top_asserts.sv]
module pwsl_top_asserts (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // watched ports
    input wire logic [5:0] i_tick,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic [5:0] o_waveform,
    input wire logic [15:0] o_counter_value [6],
    input wire logic [5:0] o_dir_up
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_req_waits: assert property ($rose(i_read | i_write) |-> o_waitrequest)
        else $error("request not held off in its first cycle");
    a_ack_next: assert property ((i_read | i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("answer not given one cycle after request");
    a_idle_nowait: assert property (!(i_read | i_write) |-> !o_waitrequest)
        else $error("wait raised with no request");
    a_rdata_holds: assert property (!$past(i_read) |-> $stable(o_readdata))
        else $error("read data moved without a read");
    a_reset_vals: assert property ($rose(i_rst_b) |-> o_waveform == 6'h00 && o_dir_up == 6'h3f)
        else $error("outputs not at reset values");
    a_cnt_needs_tick: assert property (
        !i_tick[0] && !$past(i_tick[0]) && !i_write && !$past(i_write) |=> $stable(o_counter_value[0]))
        else $error("counter moved without a tick");
    a_wave_needs_tick: assert property (
        $changed(o_waveform) |-> $past(|i_tick) || $past(|i_tick, 2))
        else $error("waveform moved without a tick");
    a_dir_needs_tick: assert property (
        $changed(o_dir_up) |-> $past(|i_tick) || $past(i_write) || $past(i_write, 2))
        else $error("direction moved without a tick");
endmodule

bind pwsl_top pwsl_top_asserts u_chk (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_tick(i_tick),
    .i_read(i_read),
    .i_write(i_write),
    .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest),
    .o_waveform(o_waveform),
    .o_counter_value(o_counter_value),
    .o_dir_up(o_dir_up)
);

// [testbench/pwsl_top_tb_top.sv]
module pwsl_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [5:0] i_tick = 6'h00;
    logic [7:0] i_address = 8'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0000_0000;
    logic [3:0] i_byteenable = 4'hf;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    logic [5:0] o_waveform;
    logic [15:0] o_counter_value [6];
    logic [5:0] o_dir_up;
    logic [31:0] rd;
    logic [31:0] exp_v;
    int errors = 0;
    int cmp_count = 0;

    pwsl_top uut (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_tick(i_tick),
        .i_address(i_address),
        .i_read(i_read),
        .i_write(i_write),
        .i_writedata(i_writedata),
        .i_byteenable(i_byteenable),
        .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest),
        .o_waveform(o_waveform),
        .o_counter_value(o_counter_value),
        .o_dir_up(o_dir_up)
    );

    initial begin
        forever #20 i_clk = ~i_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_address <= a;
        i_writedata <= d;
        i_write <= is_wr;
        i_read <= ~is_wr;
        @(posedge i_clk);
        while (o_waitrequest) begin
            @(posedge i_clk);
        end
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // n counter-clock pulses, then let the waveform settle
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge i_clk);
            i_tick <= 6'h3f;
            @(posedge i_clk);
            i_tick <= 6'h00;
        end
        repeat (3) @(posedge i_clk);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        // reset values, unmapped place included
        for (int a = 0; a <= 'h40; a += 4) begin
            exp_v = (a == 'h28) ? 32'h003f_0000 : (a == 'h34) ? 32'h0001_0000 : 32'h0000_0000;
            rdchk(8'(a), exp_v);
        end
        wr(8'h40, 32'h1234_5678);
        rdchk(8'h40, 32'h0000_0000);
        $display("test reset done");
        // immediate load, then period-end load with actions
        wr(8'h00, 32'h0001_0000);
        wr(8'h14, 32'h0000_0004);
        wr(8'h18, 32'h0000_0002);
        rdchk(8'h2c, 32'h0000_0004);
        rdchk(8'h30, 32'h0000_0002);
        wr(8'h00, 32'h0000_0000);
        wr(8'h20, 32'h0000_0009);
        wr(8'h08, 32'h0000_0001);
        wr(8'h14, 32'h0000_0006);
        wr(8'h18, 32'h0000_0003);
        ticks(2);
        rdchk(8'h2c, 32'h0000_0004);
        chk({16'h0000, o_counter_value[0]}, 32'h0000_0002);
        ticks(2);
        chk({31'h0, o_waveform[0]}, 32'h0000_0000);
        ticks(1);
        chk({31'h0, o_waveform[0]}, 32'h0000_0001);
        rdchk(8'h2c, 32'h0000_0006);
        rdchk(8'h30, 32'h0000_0003);
        $display("test period load done");
        // window load
        wr(8'h00, 32'h0000_0100);
        wr(8'h18, 32'h0000_0005);
        wr(8'h14, 32'h0000_0004);
        ticks(7);
        rdchk(8'h2c, 32'h0000_0004);
        rdchk(8'h30, 32'h0000_0003);
        wr(8'h0c, 32'h0000_0001);
        rdchk(8'h0c, 32'h0000_0001);
        ticks(5);
        rdchk(8'h30, 32'h0000_0005);
        rdchk(8'h0c, 32'h0000_0000);
        wr(8'h10, 32'h0000_0001);
        rdchk(8'h2c, 32'h0000_0000);
        rdchk(8'h30, 32'h0000_0000);
        wr(8'h10, 32'h0000_0000);
        $display("test window load done");
        // immediate period below count, then zero period
        wr(8'h00, 32'h0001_0000);
        ticks(3);
        chk({31'h0, o_waveform[0]}, 32'h0000_0000);
        wr(8'h14, 32'h0000_0002);
        ticks(1);
        chk({16'h0000, o_counter_value[0]}, 32'h0000_0004);
        wr(8'h14, 32'h0000_0000);
        ticks(1);
        chk({16'h0000, o_counter_value[0]}, 32'h0000_0000);
        $display("test immediate done");
        // one-shot stop and retrigger
        wr(8'h14, 32'h0000_0003);
        wr(8'h04, 32'h0001_0000);
        ticks(4);
        ticks(2);
        chk({16'h0000, o_counter_value[0]}, 32'h0000_0000);
        wr(8'h18, 32'h0000_0001);
        ticks(2);
        chk({16'h0000, o_counter_value[0]}, 32'h0000_0002);
        $display("test one-shot done");
        // up-down counting with center load
        wr(8'h08, 32'h0000_0000);
        wr(8'h04, 32'h0000_0002);
        wr(8'h00, 32'h0000_0001);
        wr(8'h18, 32'h0000_0002);
        wr(8'h08, 32'h0000_0001);
        ticks(4);
        rdchk(8'h30, 32'h0000_0002);
        chk({31'h0, o_waveform[0]}, 32'h0000_0001);
        ticks(3);
        chk({31'h0, o_waveform[0]}, 32'h0000_0000);
        rdchk(8'h34, 32'h0001_0001);
        $display("test up-down done");
        wrap_up();
    end
endmodule
